/* File: design/rtt_defines.vh */
`ifndef RTT_DEFINES_VH
`define RTT_DEFINES_VH
`define RTT_MODE_DELAY 2'h0
`define RTT_MODE_PULSE 2'h1
`define RTT_MODE_TOGGLE 2'h2
`define RTT_EDGE_RISE 1'h0
`define RTT_EDGE_FALL 1'h1
`define RTT_CLK_HZ 50000000
`define RTT_DELAY_MS 5000
`define RTT_PULSE_MS 5000
`define RTT_DEBOUNCE_US 10000
`define RTT_DELAY_CYC ((`RTT_CLK_HZ / 1000) * `RTT_DELAY_MS)
`define RTT_PULSE_CYC ((`RTT_CLK_HZ / 1000) * `RTT_PULSE_MS)
`define RTT_DEBOUNCE_CYC ((`RTT_CLK_HZ / 1000000) * `RTT_DEBOUNCE_US)
`define RTT_RST_RELAY 1'h0
`endif

/* File: design/rtt_relay_timer.v */
`timescale 1ns/1ns
`include "rtt_defines.vh"
module rtt_relay_timer
#(
	parameter [1:0]  MODE         = `RTT_MODE_DELAY,
	parameter        TOGGLE_EDGE  = `RTT_EDGE_RISE,
	parameter [31:0] DELAY_CYC    = `RTT_DELAY_CYC,
	parameter [31:0] PULSE_CYC    = `RTT_PULSE_CYC,
	parameter [31:0] DEBOUNCE_CYC = `RTT_DEBOUNCE_CYC
)
(
	input  wire ref_clk,
	input  wire rst,
	input  wire switched_control_input,
	output reg  relay_coil_q,
	output reg  control_level_q
);
	// Three-stage sync; a change is accepted once stages two and three agree.
	reg        sync1_q;
	reg        sync2_q;
	reg        sync3_q;
	reg        stable_q;
	reg [31:0] bounce_cnt_q;
	reg        filt_q;
	reg        filt_prev_q;
	reg [3:0]  state_q;
	reg [3:0]  state_d;
	reg        relay_d;
	reg [31:0] time_cnt_q;
	reg [31:0] time_cnt_d;
	reg        stable_d;
	reg        filt_d;
	reg [31:0] bounce_cnt_d;
	wire       agree;
	wire       rise;
	wire       fall;
	wire       hit;

	// Each build uses only the states of its own mode.
	localparam [3:0] ST_DLY_OFF  = 4'h0;
	localparam [3:0] ST_DLY_RISE = 4'h1;
	localparam [3:0] ST_DLY_ON   = 4'h2;
	localparam [3:0] ST_DLY_FALL = 4'h3;
	localparam [3:0] ST_PLS_IDLE = 4'h4;
	localparam [3:0] ST_PLS_RUN  = 4'h5;
	localparam [3:0] ST_TGL_BOOT = 4'h6;
	localparam [3:0] ST_TGL_OFF  = 4'h7;
	localparam [3:0] ST_TGL_ON   = 4'h8;

	// A limit of zero is taken as one, so a count can never run away.
	function cnt_done;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			if (lim == 32'h0)
				cnt_done = 1'h1;
			else
				cnt_done = (cnt >= lim - 32'h1);
		end
	endfunction

	// Reset lands each build in the first state of its own mode.
	function [3:0] home_state;
		input [1:0] mode;
		begin
			case (mode)
			`RTT_MODE_PULSE:
				home_state = ST_PLS_IDLE;
			`RTT_MODE_TOGGLE:
				home_state = ST_TGL_BOOT;
			default:
				home_state = ST_DLY_OFF;
			endcase
		end
	endfunction

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			sync1_q <= 1'h0;
			sync2_q <= 1'h0;
			sync3_q <= 1'h0;
		end
		else
		begin
			sync1_q <= switched_control_input;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// The filtered level moves only after the agreed level has held still
	// for the full debounce window, so a bouncing button gives one edge.
	assign agree = (sync2_q == sync3_q);

	always @*
	begin
		stable_d     = stable_q;
		filt_d       = filt_q;
		bounce_cnt_d = bounce_cnt_q;
		if (agree)
			stable_d = sync3_q;
		if (!agree || (stable_q == filt_q))
		begin
			bounce_cnt_d = 32'h0;
		end
		else if (cnt_done(bounce_cnt_q, DEBOUNCE_CYC))
		begin
			filt_d       = stable_q;
			bounce_cnt_d = 32'h0;
		end
		else
		begin
			bounce_cnt_d = bounce_cnt_q + 32'h1;
		end
	end

	// The previous filtered level feeds the edge detectors.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			stable_q     <= 1'h0;
			bounce_cnt_q <= 32'h0;
			filt_q       <= 1'h0;
			filt_prev_q  <= 1'h0;
		end
		else
		begin
			stable_q     <= stable_d;
			bounce_cnt_q <= bounce_cnt_d;
			filt_q       <= filt_d;
			filt_prev_q  <= filt_q;
		end
	end

	assign rise = filt_q & ~filt_prev_q;
	assign fall = ~filt_q & filt_prev_q;
	assign hit  = (TOGGLE_EDGE == `RTT_EDGE_FALL) ? fall : rise;

	// Next state and next relay level; the registers below hold both.
	always @*
	begin
		state_d    = state_q;
		relay_d    = relay_coil_q;
		time_cnt_d = time_cnt_q;
		case (state_q)
		ST_DLY_OFF:
		begin
			if (filt_q)
			begin
				state_d    = ST_DLY_RISE;
				time_cnt_d = 32'h1;
			end
			else
			begin
				time_cnt_d = 32'h0;
			end
		end

		ST_DLY_RISE:
		begin
			// A level that drops back early cancels the wait.
			if (!filt_q)
			begin
				state_d    = ST_DLY_OFF;
				time_cnt_d = 32'h0;
			end
			else if (cnt_done(time_cnt_q, DELAY_CYC))
			begin
				state_d    = ST_DLY_ON;
				relay_d    = 1'h1;
				time_cnt_d = 32'h0;
			end
			else
			begin
				time_cnt_d = time_cnt_q + 32'h1;
			end
		end

		ST_DLY_ON:
		begin
			if (!filt_q)
			begin
				state_d    = ST_DLY_FALL;
				time_cnt_d = 32'h1;
			end
			else
			begin
				time_cnt_d = 32'h0;
			end
		end

		ST_DLY_FALL:
		begin
			// The relay stays energised for the whole release wait.
			if (filt_q)
			begin
				state_d    = ST_DLY_ON;
				time_cnt_d = 32'h0;
			end
			else if (cnt_done(time_cnt_q, DELAY_CYC))
			begin
				state_d    = ST_DLY_OFF;
				relay_d    = 1'h0;
				time_cnt_d = 32'h0;
			end
			else
			begin
				time_cnt_d = time_cnt_q + 32'h1;
			end
		end

		ST_PLS_IDLE:
		begin
			time_cnt_d = 32'h0;
			if (rise)
			begin
				state_d = ST_PLS_RUN;
				relay_d = 1'h1;
			end
		end

		ST_PLS_RUN:
		begin
			// Activations here are ignored, so no retrigger.
			if (cnt_done(time_cnt_q, PULSE_CYC))
			begin
				state_d    = ST_PLS_IDLE;
				relay_d    = 1'h0;
				time_cnt_d = 32'h0;
			end
			else
			begin
				time_cnt_d = time_cnt_q + 32'h1;
			end
		end

		ST_TGL_BOOT:
		begin
			// Waking up counts as a falling edge, so a falling-edge build pulls the relay in.
			if (TOGGLE_EDGE == `RTT_EDGE_FALL)
			begin
				state_d = ST_TGL_ON;
				relay_d = 1'h1;
			end
			else
			begin
				state_d = ST_TGL_OFF;
			end
		end

		ST_TGL_OFF:
		begin
			if (hit)
			begin
				state_d = ST_TGL_ON;
				relay_d = 1'h1;
			end
		end

		ST_TGL_ON:
		begin
			if (hit)
			begin
				state_d = ST_TGL_OFF;
				relay_d = 1'h0;
			end
		end

		default:
		begin
			state_d    = home_state(MODE);
			relay_d    = `RTT_RST_RELAY;
			time_cnt_d = 32'h0;
		end
		endcase
	end

	// Times are fixed per build; nothing at run time can alter them.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q    <= home_state(MODE);
			time_cnt_q <= 32'h0;
		end
		else
		begin
			state_q    <= state_d;
			time_cnt_q <= time_cnt_d;
		end
	end

	// Both outputs come straight from these flops.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			relay_coil_q    <= `RTT_RST_RELAY;
			control_level_q <= 1'h0;
		end
		else
		begin
			relay_coil_q    <= relay_d;
			control_level_q <= filt_q;
		end
	end
endmodule // rtt_relay_timer

/* File: test/rtt_button.sv */
`timescale 1ns/1ns
module rtt_button (output logic sw);
	initial sw = 1'h0;
	// Chatter stays shorter than the filter window, so it must be swallowed.
	task push(input logic v);
		repeat (3) #25 sw = ~sw;
		#25 sw = v;
	endtask
endmodule // rtt_button

/* File: test/rtt_chk_asserts.sv */
`timescale 1ns/1ns
module rtt_chk #(parameter [1:0] MODE = 2'h0, parameter TOGGLE_EDGE = 1'h0,
	parameter [31:0] DELAY_CYC = 32'h14, parameter [31:0] PULSE_CYC = 32'h14)
(
	input wire ref_clk,
	input wire rst,
	input wire switched_control_input,
	input wire relay_coil_q,
	input wire control_level_q
);
	localparam int P1 = PULSE_CYC - 1;
	wire r = relay_coil_q, l = control_level_q, e = TOGGLE_EDGE ? !l : l;
	wire d = MODE == 2'h0, p = MODE == 2'h1, t = MODE == 2'h2;
	int c = 0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A disagreement that ends early clears the count, as the relay must.
	always @(posedge ref_clk) c <= rst || l == r ? 0 : c + 1;
	pls_len_a: assert property (p && $rose(r) |->
		(r throughout ##P1 1) ##1 !r) else $error("pulse");
	pls_once_a: assert property (p && $rose(r) |->
		l && !$past(l, 3)) else $error("retrigger");
	tgl_edge_a: assert property (t && $rose(e) |->
		##[0:1] $changed(r)) else $error("toggle");
	tgl_hold_a: assert property (t && $changed(r) && !$past(rst, 2) |->
		e && !$past(e, 3)) else $error("stray");
	pwr_edge_a: assert property (t && $past(rst) |->
		##1 r == TOGGLE_EDGE) else $error("power-up");
	dly_early_a: assert property (
		d && $changed(r) && !$past(rst) |-> c >= DELAY_CYC - 1)
		else $error("early");
	dly_late_a: assert property (
		d |-> c <= DELAY_CYC) else $error("late");
	in_sync_a: assert property (
		$changed(l) && !$past(rst) |-> $past(switched_control_input, 3) == l)
		else $error("unfiltered");
	cover property (p && $fell(r));
	cover property (d && $fell(r));
	cover property (t && $changed(r));
endmodule // rtt_chk
bind rtt_relay_timer rtt_chk #(.MODE(MODE), .TOGGLE_EDGE(TOGGLE_EDGE),
	.DELAY_CYC(DELAY_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (.ref_clk, .rst,
	.switched_control_input, .relay_coil_q, .control_level_q);

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	logic       ref_clk = 1'h0;
	logic       rst = 1'h1;
	wire        switched_control_input;
	wire  [3:0] r;
	wire  [3:0] lv;
	int         error_cnt = 0, n_tests = 0, cyc = 0;
	always #10 ref_clk = ~ref_clk;
	rtt_button btn (.sw(switched_control_input));
	for (genvar i = 0; i < 4; i++)
	begin : g
		rtt_relay_timer #(.MODE(2'(i > 1 ? 2 : i)), .TOGGLE_EDGE(i == 3),
			.DELAY_CYC(32'h14), .PULSE_CYC(32'h20), .DEBOUNCE_CYC(32'h4))
			dut (.ref_clk, .rst, .switched_control_input,
			.relay_coil_q(r[i]), .control_level_q(lv[i]));
	end
	task check(input string name, input logic [3:0] seen,
		input logic [3:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %b got %b", name, exp, seen);
		end
	endtask
	task step(input logic v, input int n, input logic [3:0] e);
		btn.push(v);
		repeat (n) @(posedge ref_clk);
		#2 check("relays", r, e);
		if (n >= 12)
			check("levels", lv, {4{v}});
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task t_hold;
		step(1'h0, 3, 4'h8);
		step(1'h1, 15, 4'he);
		step(1'h1, 40, 4'hd);
		step(1'h0, 15, 4'h5);
		step(1'h0, 30, 4'h4);
		$display("hold test done");
	endtask
	task t_retrig;
		step(1'h1, 12, 4'h2);
		step(1'h0, 5, 4'h2);
		step(1'h1, 25, 4'hc);
		$display("retrigger test done");
	endtask
	always @(posedge ref_clk)
		if (++cyc == 1000)
		begin
			error_cnt++;
			summarize;
		end
	initial
	begin
		repeat (16) @(posedge ref_clk);
		#2 rst = 1'h0;
		t_hold;
		t_retrig;
		summarize;
	end
endmodule // tb_top
